// >>> rtl/cim_params.svh
`ifndef CIM_PARAMS_SVH
`define CIM_PARAMS_SVH

// oscillator clocks in one machine cycle
`define CIM_MC_CLKS 12
// machine cycles the core may run on after a reset ends idle
`define CIM_RST_WIN_MC 2
// number of interrupt sources
`define CIM_IRQ_N 6
// divider and window counter widths
`define CIM_DIV_W 4
`define CIM_WIN_W 2
// reset values
`define CIM_DIV_RST 4'h0
`define CIM_WIN_RST 2'h0

`endif

// >>> rtl/cim_pkg.sv
`default_nettype none
`include "cim_params.svh"

package cim_pkg;

   typedef enum logic [1:0] {
      CIM_RUN   = 2'b00,
      CIM_SLEEP = 2'b01,
      CIM_WIN   = 2'b10,
      CIM_RSEQ  = 2'b11
   } cim_state_t;

   typedef struct packed {
      cim_state_t state;
      logic [`CIM_DIV_W-1:0] div;
      logic [`CIM_WIN_W-1:0] win;
      logic wake;
   } cim_regs_t;

endpackage

`default_nettype wire

// >>> rtl/cim_idle_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "cim_params.svh"

module cim_idle_ctrl
   import cim_pkg::*;
#(
   parameter int IRQ_N = `CIM_IRQ_N,
   parameter int MC_CLKS = `CIM_MC_CLKS,
   parameter int RST_WIN_MC = `CIM_RST_WIN_MC
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic idle_enter_i,
   input wire logic global_interrupt_enable_i,
   input wire logic [IRQ_N-1:0] irq_enable_i,
   input wire logic [IRQ_N-1:0] irq_pending_i,
   input wire logic rst_pin_i,
   input wire logic cpu_ram_we_i,
   input wire logic cpu_sfr_we_i,
   input wire logic cpu_port_we_i,
   output logic mc_tick_o,
   output logic idle_o,
   output logic cpu_halt_o,
   output logic ram_we_o,
   output logic sfr_we_o,
   output logic port_we_o,
   output logic core_reset_o,
   output logic irq_wake_o
);

   localparam logic [`CIM_DIV_W-1:0] DIV_LAST = (`CIM_DIV_W)'(MC_CLKS - 1);
   localparam logic [`CIM_WIN_W-1:0] WIN_LAST = (`CIM_WIN_W)'(RST_WIN_MC - 1);

   cim_regs_t r;
   cim_regs_t n;
   logic mc_tick;
   logic wake_req;
   logic in_sleep;
   logic in_win;

   assign mc_tick = (r.div == DIV_LAST);
   assign in_sleep = (r.state == CIM_SLEEP);
   assign in_win = (r.state == CIM_WIN);
   // the global enable gates the OR of the enabled sources after the reduction
   assign wake_req = global_interrupt_enable_i && |(irq_pending_i & irq_enable_i);

   always_comb begin
      n = r;
      n.wake = 1'h0;
      // the divider never stops, so timers and uart keep counting in idle
      n.div = mc_tick ? `CIM_DIV_RST : r.div + 1'h1;
      case (r.state)
         CIM_RUN: begin
            if (rst_pin_i) begin
               n.state = CIM_RSEQ;
            end else if (idle_enter_i) begin
               n.state = CIM_SLEEP;
            end
         end
         CIM_SLEEP: begin
            // reset wins over a wake that arrives in the same cycle
            if (rst_pin_i) begin
               n.state = CIM_WIN;
               n.win = `CIM_WIN_RST;
            end else if (wake_req) begin
               n.state = CIM_RUN;
               n.wake = 1'h1;
            end
         end
         CIM_WIN: begin
            if (mc_tick) begin
               if (r.win == WIN_LAST) begin
                  n.state = CIM_RSEQ;
               end else begin
                  n.win = r.win + 1'h1;
               end
            end
         end
         CIM_RSEQ: begin
            if (!rst_pin_i) begin
               n.state = CIM_RUN;
            end
         end
         default: begin
            n.state = CIM_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r.state <= CIM_RUN;
         r.div <= `CIM_DIV_RST;
         r.win <= `CIM_WIN_RST;
         r.wake <= 1'h0;
      end else begin
         r <= n;
      end
   end

   assign mc_tick_o = mc_tick;
   assign idle_o = in_sleep;
   assign cpu_halt_o = in_sleep;
   // a halted core should not write, but the gate keeps state safe regardless
   assign ram_we_o = cpu_ram_we_i && !in_sleep && !in_win;
   assign sfr_we_o = cpu_sfr_we_i && !in_sleep;
   // ports stay writable in the window; software must avoid that itself
   assign port_we_o = cpu_port_we_i && !in_sleep;
   assign core_reset_o = (r.state == CIM_RSEQ);
   // core vectors to the interrupt; its saved return is the next instruction
   assign irq_wake_o = r.wake;

   localparam int WIN_MAX = `CIM_MC_CLKS * `CIM_RST_WIN_MC;
   localparam int MC_MAX = `CIM_MC_CLKS;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence seq_win_enter;
      in_sleep && rst_pin_i;
   endsequence

   sequence seq_win_run;
      in_win && !core_reset_o;
   endsequence

   sequence seq_irq_wake;
      in_sleep && !rst_pin_i && wake_req;
   endsequence

   a_idle_periph_tick: assert property (
      $rose(idle_o) |-> ##[0:MC_MAX] mc_tick_o)
      else $error("machine-cycle tick stopped in idle");

   a_idle_halt_cpu: assert property (
      (r.state == CIM_RUN) && idle_enter_i && !rst_pin_i |=> cpu_halt_o && idle_o)
      else $error("idle request did not halt the cpu");

   a_idle_hold_state: assert property (
      idle_o |-> !ram_we_o && !sfr_we_o)
      else $error("ram or sfr written while idle");

   a_irq_exit_idle: assert property (
      seq_irq_wake |=> !idle_o && irq_wake_o)
      else $error("enabled interrupt did not end idle");

   a_win_bounded: assert property (
      seq_win_enter |=> seq_win_run ##[0:WIN_MAX] core_reset_o)
      else $error("reset window too long or missing");

   a_win_ram_block: assert property (
      in_win |-> !ram_we_o && (port_we_o == cpu_port_we_i))
      else $error("window access gating wrong");

   a_mask_no_wake: assert property (
      in_sleep && !rst_pin_i && !global_interrupt_enable_i |=> idle_o && !irq_wake_o)
      else $error("woke with global enable clear");

   a_wake_resume: assert property (
      irq_wake_o |-> !cpu_halt_o && !core_reset_o && $past(idle_o))
      else $error("interrupt exit did not resume the core");

   // reset-pin paths: the pin always wins over idle entry and over a wake
   sequence seq_run_rst;
      (r.state == CIM_RUN) && rst_pin_i;
   endsequence

   sequence seq_rseq_release;
      core_reset_o && !rst_pin_i;
   endsequence

   sequence seq_rst_race;
      in_sleep && rst_pin_i && wake_req;
   endsequence

   // peripherals see an unbroken machine-cycle rate whatever the core does
   a_tick_period: assert property (
      mc_tick_o |-> ##MC_MAX mc_tick_o)
      else $error("machine-cycle tick period wrong");

   a_tick_pulse: assert property (
      mc_tick_o |=> !mc_tick_o)
      else $error("machine-cycle tick longer than one cycle");

   a_run_gates_open: assert property (
      (r.state == CIM_RUN) |-> (ram_we_o == cpu_ram_we_i) && (sfr_we_o == cpu_sfr_we_i)
         && (port_we_o == cpu_port_we_i))
      else $error("write gate closed while running");

   a_rst_leave_idle: assert property (
      seq_win_enter |=> !idle_o && !cpu_halt_o)
      else $error("reset pin did not end idle");

   a_rst_beats_wake: assert property (
      seq_rst_race |=> in_win && !irq_wake_o)
      else $error("wake taken over a reset pin");

   a_run_rst_direct: assert property (
      seq_run_rst |=> core_reset_o && !idle_o)
      else $error("reset pin in run did not reset the core");

   a_win_no_wake: assert property (
      in_win |=> !irq_wake_o)
      else $error("interrupt wake raised in the reset window");

   a_rseq_release: assert property (
      seq_rseq_release |=> !core_reset_o)
      else $error("core reset held after the pin fell");

   a_src_no_wake: assert property (
      in_sleep && !rst_pin_i && !(|(irq_pending_i & irq_enable_i)) |=> idle_o && !irq_wake_o)
      else $error("woke with no enabled source pending");

   a_wake_one_cycle: assert property (
      irq_wake_o |=> !irq_wake_o)
      else $error("interrupt wake longer than one cycle");

endmodule

`default_nettype wire

// >>> verification/cim_idle_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cim_params.svh"
module cim_idle_ctrl_tb;
   logic clk = 0, rst = 1, req = 0, gie = 0, rpin = 0;
   logic ram_we = 1, sfr_we = 1, port_we = 1;
   logic [5:0] irq_en = 6'h00, irq_pend = 6'h00;
   logic tick, idle, halt, ram_q, sfr_q, port_q, core_rst, wake;
   int err_count = 0;
   int tests_run = 0;
   cim_idle_ctrl u_dut (.ref_clk_i(clk), .sys_rst_i(rst), .idle_enter_i(req),
      .global_interrupt_enable_i(gie), .irq_enable_i(irq_en), .irq_pending_i(irq_pend),
      .rst_pin_i(rpin), .cpu_ram_we_i(ram_we), .cpu_sfr_we_i(sfr_we),
      .cpu_port_we_i(port_we), .mc_tick_o(tick), .idle_o(idle), .cpu_halt_o(halt),
      .ram_we_o(ram_q), .sfr_we_o(sfr_q), .port_we_o(port_q), .core_reset_o(core_rst),
      .irq_wake_o(wake));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic t_enter;
      req = 1;
      cyc(1);
      req = 0;
      chk("idle", 1, idle);
      chk("halt", 1, halt);
      chk("ram gate", 0, ram_q);
      chk("sfr gate", 0, sfr_q);
      chk("port gate", 0, port_q);
   endtask
   // masked sources must not wake; divider must keep ticking while halted
   task automatic t_wake;
      int tk;
      t_enter();
      irq_pend = 6'h04;
      irq_en = 6'h04;
      tk = 0;
      repeat (12) begin
         cyc(1);
         tk += tick;
      end
      chk("tick in idle", 1, tk == 1);
      chk("no wake gie", 1, idle);
      gie = 1;
      irq_en = 6'h08;
      cyc(2);
      chk("no wake src", 1, idle);
      irq_en = 6'h04;
      cyc(1);
      chk("wake", 1, wake);
      chk("awake", 0, idle);
      cyc(1);
      chk("wake pulse", 0, wake);
      irq_pend = 6'h00;
      gie = 0;
   endtask
   // reset pin and an enabled wake arrive together; the pin must win
   task automatic t_rst;
      int n;
      port_we = 0;
      t_enter();
      rpin = 1;
      gie = 1;
      irq_pend = 6'h04;
      cyc(1);
      chk("left idle", 0, idle);
      chk("reset beats wake", 0, wake);
      chk("ram blocked", 0, ram_q);
      chk("port quiet", 0, port_q);
      port_we = 1;
      cyc(1);
      chk("port open", 1, port_q);
      n = 2;
      while (core_rst !== 1'h1 && n < 40) begin
         chk("ram blocked win", 0, ram_q);
         cyc(1);
         n++;
      end
      chk("core reset time", 1, n >= 13 && n <= 25);
      if (n >= 40) begin
         results();
      end
      rpin = 0;
      gie = 0;
      irq_pend = 6'h00;
      cyc(2);
      chk("core reset off", 0, core_rst);
      chk("no wake after reset", 0, wake);
   endtask
   task automatic t_run_rst;
      rpin = 1;
      req = 1;
      cyc(1);
      req = 0;
      chk("run reset", 1, core_rst);
      chk("reset beats idle", 0, idle);
      rpin = 0;
      cyc(1);
      chk("run reset off", 0, core_rst);
   endtask
   // system reset in the middle of idle; divider restarts from zero
   task automatic t_sys_rst;
      int n;
      t_enter();
      rst = 1;
      cyc(2);
      chk("idle in reset", 0, idle);
      chk("core reset in reset", 0, core_rst);
      rst = 0;
      n = 0;
      while (tick !== 1'h1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk("first tick", 1, n == `CIM_MC_CLKS - 1);
      if (n >= 20) begin
         results();
      end
      chk("idle after sys reset", 0, idle);
      chk("wake after sys reset", 0, wake);
   endtask
   task automatic results;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      cyc(20);
      rst = 0;
      cyc(1);
      chk("idle after reset", 0, idle);
      t_wake();
      t_rst();
      t_run_rst();
      t_sys_rst();
      t_wake();
      results();
   end
endmodule
`default_nettype wire
